// ---- include/sisl_pkg.sv ----
// Constants and types shared by the servo input signal logic.
//
// Summary of operation
// - Shorting the servo enable input to the common turns the base circuit on (servo on).
// - Opening the servo enable input shuts the base circuit off so the motor coasts.
// - An auto-on control bit forces the servo enable input active whatever the pin does.
// - An alarm clears only once the clear input has stayed open longer than 50 ms.
// - Alarms of the latched type are not cleared by the alarm clear input.
// - Asserting the alarm clear input with no alarm present shuts the base circuit off.
// - By default an open travel-limit input causes a sudden stop and servo lock, both raised in the same cycle.
// - With the slow-stop control bit set, an open travel limit gives a decelerating stop.
// - A travel-limit input reads 0 when open from the common and 1 when shorted to it.
// - Two separate auto-on bits force the forward and reverse travel limits active.
package sisl_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses on the Avalon-MM slave.
  localparam logic [3:0] SISL_ADDR_CTRL = 4'h0;
  localparam logic [3:0] SISL_ADDR_STATUS = 4'h4;
  localparam logic [3:0] SISL_ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] SISL_ADDR_IRQ_MASK = 4'hC;

  // Control register fields.
  localparam int SISL_CTRL_AUTO_SON = 0;
  localparam int SISL_CTRL_AUTO_FWD = 1;
  localparam int SISL_CTRL_AUTO_REV = 2;
  localparam int SISL_CTRL_SLOW_STOP = 3;
  localparam logic [3:0] SISL_CTRL_RST = 4'h0;

  // Status register fields.
  localparam int SISL_STS_BASE_ON = 0;
  localparam int SISL_STS_ALARM = 1;
  localparam int SISL_STS_ALARM_LATCHED = 2;
  localparam int SISL_STS_CCW_PERMIT = 3;
  localparam int SISL_STS_CW_PERMIT = 4;
  localparam int SISL_STS_SUDDEN = 5;
  localparam int SISL_STS_SLOW = 6;
  localparam int SISL_STS_LOCK = 7;
  localparam int SISL_STS_CLR_TIMING = 8;

  // Interrupt status and mask fields.
  localparam int SISL_IRQ_ALARM_SET = 0;
  localparam int SISL_IRQ_ALARM_CLR = 1;
  localparam int SISL_IRQ_LIMIT_STOP = 2;
  localparam int SISL_IRQ_BASE_OFF = 3;
  localparam logic [3:0] SISL_IRQ_STAT_RST = 4'h0;
  localparam logic [3:0] SISL_IRQ_MASK_RST = 4'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing.
  localparam longint SISL_CLK_HZ = 100_000_000;
  localparam longint SISL_CLR_HOLD_MS = 50;
  localparam longint SISL_CLR_HOLD_CYC = (SISL_CLR_HOLD_MS * SISL_CLK_HZ + 999) / 1000;
  localparam int SISL_TMR_W = 32;

  ////////////////////////////////////////////////////////////////////////////////
  // State encodings.
  typedef enum logic
  {
    SISL_BUS_IDLE = 1'b0,
    SISL_BUS_ACK = 1'b1
  } sisl_bus_st_t;

  typedef enum logic [1:0]
  {
    SISL_CLR_IDLE = 2'b00,
    SISL_CLR_ARMED = 2'b01,
    SISL_CLR_TIMING = 2'b11
  } sisl_clr_st_t;

endpackage

// ---- include/sisl_hold_if.sv ----
// Carrier between the input logic and its alarm-clear hold timer.
interface sisl_hold_if;
  logic run;
  logic done;

  modport ctl
  (
    output run,
    input done
  );

  modport tmr
  (
    input run,
    output done
  );
endinterface

// ---- logic/sisl_hold_timer.sv ----
// Hold timer: reports once its run level has stayed high longer than the limit.
module sisl_hold_timer
#(
  parameter logic [sisl_pkg::SISL_TMR_W-1:0] LIMIT =
    sisl_pkg::SISL_TMR_W'(sisl_pkg::SISL_CLR_HOLD_CYC)
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  sisl_hold_if.tmr hold
);

  typedef struct packed
  {
    logic [sisl_pkg::SISL_TMR_W-1:0] cnt;
    logic done;
  } sisl_tmr_st_t;

  sisl_tmr_st_t st_r;
  sisl_tmr_st_t st_nxt;

  // The count restarts whenever run drops, so a short bounce never completes.
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (!hold.run)
    begin
      st_nxt.cnt = '0;
    end
    else if (st_r.cnt < LIMIT)
    begin
      st_nxt.cnt = st_r.cnt + sisl_pkg::SISL_TMR_W'(1);
    end
    else
    begin
      st_nxt.done = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign hold.done = st_r.done;

endmodule

// ---- logic/sisl_top.sv ----
// Servo input signal logic: enable, alarm clear and travel limits behind an Avalon-MM slave.
module sisl_top
#(
  parameter logic [sisl_pkg::SISL_TMR_W-1:0] CLR_HOLD_CYC =
    sisl_pkg::SISL_TMR_W'(sisl_pkg::SISL_CLR_HOLD_CYC)
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_servo_enable_input,
  input wire logic i_alarm_clear_input,
  input wire logic i_fwd_travel_limit_input,
  input wire logic i_rev_travel_limit_input,
  input wire logic i_alarm_event,
  input wire logic i_alarm_latched_type,
  output logic o_base_on,
  output logic o_alarm,
  output logic o_ccw_permit,
  output logic o_cw_permit,
  output logic o_sudden_stop,
  output logic o_slow_stop,
  output logic o_servo_lock,
  output logic o_irq
);

  typedef struct packed
  {
    sisl_pkg::sisl_bus_st_t bus;
    logic wait_req;
    logic [31:0] rdata;
    logic [3:0] ctrl;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    sisl_pkg::sisl_clr_st_t clr;
    logic alarm;
    logic latched;
    logic base_on;
    logic ccw;
    logic cw;
    logic sudden;
    logic slow;
    logic lock;
    logic irq;
  } sisl_top_st_t;

  sisl_top_st_t st_r;
  sisl_top_st_t st_nxt;
  sisl_hold_if hold ();

  ////////////////////////////////////////////////////////////////////////////////
  // Alarm-clear hold timer.
  sisl_hold_timer
  #(
    .LIMIT(CLR_HOLD_CYC)
  )
  u_hold
  (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .hold(hold)
  );

  assign hold.run = (st_r.clr == sisl_pkg::SISL_CLR_TIMING);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.
  logic son_eff;
  logic fwd_eff;
  logic rev_eff;
  logic alarm_cleared;
  logic limit_open;
  logic [31:0] status_word;
  logic [31:0] read_word;
  logic [3:0] irq_events;
  logic [3:0] irq_w1c;

  always_comb
  begin
    st_nxt = st_r;
    son_eff = i_servo_enable_input | st_r.ctrl[sisl_pkg::SISL_CTRL_AUTO_SON];
    // A pin high means shorted to the common, read as on.
    fwd_eff = i_fwd_travel_limit_input | st_r.ctrl[sisl_pkg::SISL_CTRL_AUTO_FWD];
    rev_eff = i_rev_travel_limit_input | st_r.ctrl[sisl_pkg::SISL_CTRL_AUTO_REV];
    alarm_cleared = 1'b0;
    irq_events = '0;
    irq_w1c = '0;

    // Alarm clear sequence: shorted, then open, then open long enough.
    unique case (st_r.clr)
      sisl_pkg::SISL_CLR_IDLE:
      begin
        if (i_alarm_clear_input)
        begin
          st_nxt.clr = sisl_pkg::SISL_CLR_ARMED;
        end
      end
      sisl_pkg::SISL_CLR_ARMED:
      begin
        if (!i_alarm_clear_input)
        begin
          st_nxt.clr = sisl_pkg::SISL_CLR_TIMING;
        end
      end
      sisl_pkg::SISL_CLR_TIMING:
      begin
        if (i_alarm_clear_input)
        begin
          st_nxt.clr = sisl_pkg::SISL_CLR_ARMED;
        end
        else if (hold.done)
        begin
          st_nxt.clr = sisl_pkg::SISL_CLR_IDLE;
          alarm_cleared = st_r.alarm & ~st_r.latched;
        end
      end
      default:
      begin
        st_nxt.clr = sisl_pkg::SISL_CLR_IDLE;
      end
    endcase

    // A new alarm in the clearing cycle wins over the clear.
    if (alarm_cleared)
    begin
      st_nxt.alarm = 1'b0;
    end
    if (i_alarm_event)
    begin
      st_nxt.alarm = 1'b1;
      st_nxt.latched = st_r.latched | i_alarm_latched_type;
    end

    // Base circuit; the clear input drops it only when no alarm is present.
    st_nxt.base_on = son_eff & ~st_nxt.alarm
      & ~(i_alarm_clear_input & ~st_r.alarm);

    // Direction gating; with the base off nothing moves and nothing is locked.
    st_nxt.ccw = st_nxt.base_on & fwd_eff;
    st_nxt.cw = st_nxt.base_on & rev_eff;
    limit_open = st_nxt.base_on & (~fwd_eff | ~rev_eff);
    st_nxt.sudden = limit_open & ~st_r.ctrl[sisl_pkg::SISL_CTRL_SLOW_STOP];
    st_nxt.slow = limit_open & st_r.ctrl[sisl_pkg::SISL_CTRL_SLOW_STOP];
    st_nxt.lock = limit_open;

    irq_events[sisl_pkg::SISL_IRQ_ALARM_SET] = i_alarm_event & ~st_r.alarm;
    irq_events[sisl_pkg::SISL_IRQ_ALARM_CLR] = alarm_cleared & ~i_alarm_event;
    irq_events[sisl_pkg::SISL_IRQ_LIMIT_STOP] = limit_open & ~st_r.lock;
    irq_events[sisl_pkg::SISL_IRQ_BASE_OFF] = st_r.base_on & ~st_nxt.base_on;

    status_word = '0;
    status_word[sisl_pkg::SISL_STS_BASE_ON] = st_r.base_on;
    status_word[sisl_pkg::SISL_STS_ALARM] = st_r.alarm;
    status_word[sisl_pkg::SISL_STS_ALARM_LATCHED] = st_r.latched;
    status_word[sisl_pkg::SISL_STS_CCW_PERMIT] = st_r.ccw;
    status_word[sisl_pkg::SISL_STS_CW_PERMIT] = st_r.cw;
    status_word[sisl_pkg::SISL_STS_SUDDEN] = st_r.sudden;
    status_word[sisl_pkg::SISL_STS_SLOW] = st_r.slow;
    status_word[sisl_pkg::SISL_STS_LOCK] = st_r.lock;
    status_word[sisl_pkg::SISL_STS_CLR_TIMING] = hold.run;

    unique case (i_avs_address)
      sisl_pkg::SISL_ADDR_CTRL: read_word = {28'h0000000, st_r.ctrl};
      sisl_pkg::SISL_ADDR_STATUS: read_word = status_word;
      sisl_pkg::SISL_ADDR_IRQ_STAT: read_word = {28'h0000000, st_r.irq_stat};
      sisl_pkg::SISL_ADDR_IRQ_MASK: read_word = {28'h0000000, st_r.irq_mask};
      default: read_word = 32'h00000000;
    endcase

    // Bus slave: one wait cycle, then the access completes with waitrequest low.
    unique case (st_r.bus)
      sisl_pkg::SISL_BUS_IDLE:
      begin
        st_nxt.wait_req = 1'b1;
        if (i_avs_read | i_avs_write)
        begin
          st_nxt.bus = sisl_pkg::SISL_BUS_ACK;
          st_nxt.wait_req = 1'b0;
          st_nxt.rdata = i_avs_read ? read_word : 32'h00000000;
        end
      end
      sisl_pkg::SISL_BUS_ACK:
      begin
        st_nxt.bus = sisl_pkg::SISL_BUS_IDLE;
        st_nxt.wait_req = 1'b1;
        if (i_avs_write & i_avs_byteenable[0])
        begin
          unique case (i_avs_address)
            sisl_pkg::SISL_ADDR_CTRL: st_nxt.ctrl = i_avs_writedata[3:0];
            sisl_pkg::SISL_ADDR_IRQ_STAT: irq_w1c = i_avs_writedata[3:0];
            sisl_pkg::SISL_ADDR_IRQ_MASK: st_nxt.irq_mask = i_avs_writedata[3:0];
            default:
            begin
            end
          endcase
        end
      end
    endcase

    // Set wins over a write-one-to-clear in the same cycle.
    st_nxt.irq_stat = (st_r.irq_stat & ~irq_w1c) | irq_events;
    st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      st_r <= '0;
      st_r.bus <= sisl_pkg::SISL_BUS_IDLE;
      st_r.wait_req <= 1'b1;
      st_r.ctrl <= sisl_pkg::SISL_CTRL_RST;
      st_r.irq_stat <= sisl_pkg::SISL_IRQ_STAT_RST;
      st_r.irq_mask <= sisl_pkg::SISL_IRQ_MASK_RST;
      st_r.clr <= sisl_pkg::SISL_CLR_IDLE;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign o_avs_readdata = st_r.rdata;
  assign o_avs_waitrequest = st_r.wait_req;
  assign o_base_on = st_r.base_on;
  assign o_alarm = st_r.alarm;
  assign o_ccw_permit = st_r.ccw;
  assign o_cw_permit = st_r.cw;
  assign o_sudden_stop = st_r.sudden;
  assign o_slow_stop = st_r.slow;
  assign o_servo_lock = st_r.lock;
  assign o_irq = st_r.irq;

endmodule

// ---- dv/sisl_contacts.sv ----
// Contact bank model of the host controller driving the discrete inputs.
module sisl_contacts
(
  input wire logic i_sys_clk,
  input wire logic [3:0] i_cmd,
  output logic o_son = 1'b0,
  output logic o_clr = 1'b0,
  output logic o_fwd = 1'b1,
  output logic o_rev = 1'b1
);
  timeunit 1ns;
  timeprecision 1ns;
  // Contacts follow the controller one clock late, like a relay driver.
  always @(posedge i_sys_clk)
  begin
    {o_rev, o_fwd, o_clr, o_son} <= i_cmd;
  end
endmodule

// ---- dv/sisl_checker.sv ----
// Port level assertions for the servo input signal logic.
module sisl_checker
#(
  parameter logic [sisl_pkg::SISL_TMR_W-1:0] CLR_HOLD_CYC = 32'h14
)
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire logic i_servo_enable_input,
  input wire logic i_alarm_clear_input,
  input wire logic i_fwd_travel_limit_input,
  input wire logic i_rev_travel_limit_input,
  input wire logic i_alarm_event,
  input wire logic i_alarm_latched_type,
  input wire logic o_base_on,
  input wire logic o_alarm,
  input wire logic o_ccw_permit,
  input wire logic o_cw_permit,
  input wire logic o_sudden_stop,
  input wire logic o_slow_stop,
  input wire logic o_servo_lock
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] ctrl_r;
  logic lat_r;
  logic [31:0] low_r;
  logic fwd_e;
  logic rev_e;
  logic son_e;
  assign fwd_e = i_fwd_travel_limit_input | ctrl_r[1];
  assign rev_e = i_rev_travel_limit_input | ctrl_r[2];
  assign son_e = i_servo_enable_input | ctrl_r[0];
  // Shadow of the control register, so forced inputs are known here.
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_n)
    begin
      ctrl_r <= 4'h0;
      lat_r <= 1'b0;
      low_r <= 32'h0;
    end
    else
    begin
      if (i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h0 && i_avs_byteenable[0])
        ctrl_r <= i_avs_writedata[3:0];
      if (i_alarm_event && i_alarm_latched_type)
        lat_r <= 1'b1;
      low_r <= i_alarm_clear_input ? 32'h0 : low_r + 32'h1;
    end
  end
  //////////////////////////////
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sequence acc_s;
    (i_avs_read || i_avs_write) && o_avs_waitrequest ##1 !o_avs_waitrequest;
  endsequence
  bus_wait_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
    |=> !o_avs_waitrequest) else $error("access not answered in one cycle");
  bus_release_a: assert property (acc_s |=> o_avs_waitrequest)
    else $error("waitrequest low too long");
  base_on_a: assert property (son_e && !i_alarm_clear_input && !o_alarm && !i_alarm_event
    |=> o_base_on) else $error("base circuit not on");
  base_off_a: assert property (!son_e |=> !o_base_on) else $error("base on without enable");
  clear_off_a: assert property (i_alarm_clear_input && !o_alarm |=> !o_base_on)
    else $error("base on during clear");
  latched_keep_a: assert property (lat_r && o_alarm |=> o_alarm)
    else $error("latched alarm cleared");
  clear_hold_a: assert property ($fell(o_alarm) |-> low_r >= CLR_HOLD_CYC)
    else $error("alarm cleared too early");
  ccw_gate_a: assert property (1'b1 |=> o_ccw_permit == (o_base_on && $past(fwd_e)))
    else $error("ccw permit wrong");
  cw_gate_a: assert property (1'b1 |=> o_cw_permit == (o_base_on && $past(rev_e)))
    else $error("cw permit wrong");
  limit_lock_a: assert property (1'b1 |=> o_servo_lock ==
    (o_base_on && !($past(fwd_e) && $past(rev_e)))) else $error("servo lock wrong");
  stop_mode_a: assert property (1'b1 |=> {o_sudden_stop, o_slow_stop} ==
    {o_servo_lock && !$past(ctrl_r[3]), o_servo_lock && $past(ctrl_r[3])})
    else $error("stop mode wrong");
endmodule

bind sisl_top sisl_checker #(.CLR_HOLD_CYC(CLR_HOLD_CYC)) chk_i (.i_sys_clk, .i_rst_n,
  .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
  .o_avs_waitrequest, .i_servo_enable_input, .i_alarm_clear_input, .i_fwd_travel_limit_input,
  .i_rev_travel_limit_input, .i_alarm_event, .i_alarm_latched_type, .o_base_on, .o_alarm,
  .o_ccw_permit, .o_cw_permit, .o_sudden_stop, .o_slow_stop, .o_servo_lock);

// ---- dv/sisl_top_tb.sv ----
// Self-checking bench for the servo input signal logic.
module sisl_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 20;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_avs_address = 4'h0;
  logic i_avs_read = 1'b0;
  logic i_avs_write = 1'b0;
  logic [31:0] i_avs_writedata = 32'h0;
  logic [31:0] o_avs_readdata;
  logic o_avs_waitrequest;
  logic i_servo_enable_input, i_alarm_clear_input;
  logic i_fwd_travel_limit_input, i_rev_travel_limit_input;
  logic i_alarm_event = 1'b0;
  logic i_alarm_latched_type = 1'b0;
  logic o_base_on, o_alarm, o_ccw_permit, o_cw_permit;
  logic o_sudden_stop, o_slow_stop, o_servo_lock, o_irq;
  logic [3:0] cmd = 4'hC;
  logic [31:0] q, x, y;
  logic [3:0] adr [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
  int num_errors = 0;
  int comparisons = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  sisl_top #(.CLR_HOLD_CYC(32'(HOLD))) dut (.i_sys_clk, .i_rst_n, .i_avs_address,
    .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable(4'hF), .o_avs_readdata,
    .o_avs_waitrequest, .i_servo_enable_input, .i_alarm_clear_input, .i_fwd_travel_limit_input,
    .i_rev_travel_limit_input, .i_alarm_event, .i_alarm_latched_type, .o_base_on, .o_alarm,
    .o_ccw_permit, .o_cw_permit, .o_sudden_stop, .o_slow_stop, .o_servo_lock, .o_irq);
  sisl_contacts partner (.i_sys_clk, .i_cmd(cmd), .o_son(i_servo_enable_input),
    .o_clr(i_alarm_clear_input), .o_fwd(i_fwd_travel_limit_input),
    .o_rev(i_rev_travel_limit_input));
  //////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] exp_sts(input logic b, f, r, s);
    logic lk;
    lk = b & ~(f & r);
    return {24'h0, lk, lk & s, lk & ~s, b & r, b & f, 2'h0, b};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_avs_read <= ~w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= d;
    // A slave that never answers is left to the watchdog, which fails the run.
    do
    begin
      @(posedge i_sys_clk);
    end
    while (o_avs_waitrequest !== 1'b0);
    q = o_avs_readdata;
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask
  task automatic alarm_run(input logic lat);
    i_alarm_latched_type <= lat;
    i_alarm_event <= 1'b1;
    @(posedge i_sys_clk);
    i_alarm_event <= 1'b0;
    cmd <= 4'hF;
    repeat (3) @(posedge i_sys_clk);
    chk(32'(o_alarm), 1);
    cmd <= 4'hD;
    repeat (HOLD) @(posedge i_sys_clk);
    chk(32'(o_alarm), 1);
    repeat (10) @(posedge i_sys_clk);
    chk(32'(o_alarm), 32'(lat));
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  //////////////////////////////
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    num_errors++;
    wrap_up();
  end
  initial
  begin
    x = 32'hDBB0;
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    foreach (adr[i])
    begin
      bus(1'b0, adr[i], 32'h0);
      chk(q, 32'h0);
    end
    cmd <= 4'hD;
    repeat (3) @(posedge i_sys_clk);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, exp_sts(1'b1, 1'b1, 1'b1, 1'b0));
    cmd <= 4'hC;
    repeat (3) @(posedge i_sys_clk);
    bus(1'b0, 4'h4, 32'h0);
    chk(q, 32'h0);
    bus(1'b1, 4'hC, 32'h8);
    repeat (2) @(posedge i_sys_clk);
    chk(32'(o_irq), 1);
    bus(1'b1, 4'h8, 32'h8);
    repeat (2) @(posedge i_sys_clk);
    chk(32'(o_irq), 0);
    // The first two passes force the slow and the sudden stop with both limits open.
    for (int i = 0; i < 14; i++)
    begin
      x = lfsr(x);
      y = (i == 0) ? 32'h48 : (i == 1) ? 32'h40 : x;
      bus(1'b1, 4'h0, y & 32'hF);
      cmd <= {y[5], y[4], 1'b0, y[6]};
      repeat (3) @(posedge i_sys_clk);
      bus(1'b0, 4'h0, 32'h0);
      chk(q, y & 32'hF);
      bus(1'b0, 4'h4, 32'h0);
      chk(q, exp_sts(y[6] | y[0], y[4] | y[1], y[5] | y[2], y[3]));
    end
    bus(1'b1, 4'h0, 32'h0);
    cmd <= 4'hF;
    repeat (3) @(posedge i_sys_clk);
    chk(32'(o_base_on), 0);
    cmd <= 4'hD;
    repeat (3) @(posedge i_sys_clk);
    chk(32'(o_base_on), 1);
    alarm_run(1'b0);
    // By now an alarm was raised and cleared, a limit stop entered and the base dropped.
    bus(1'b0, 4'h8, 32'h0);
    chk(q, 32'hF);
    alarm_run(1'b1);
    i_rst_n <= 1'b0;
    repeat (3) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    chk(32'(o_base_on), 1);
    wrap_up();
  end
endmodule
